// ==== scan_queue_ctrl.sv ====
// Continuous-scan queue sequencer of a queued converter, with APB register access.
// Assumes conversion data is a synchronous input; trigger pins are synchronised here; one clock pclk.
`timescale 1ns/100ps
`include "scan_queue_regs.svh"

module scan_queue_ctrl
    import scan_queue_pkg::*;
#(
    parameter int CONV_QCLKS = 18
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_trig1,
    input  wire logic        ext_trig2,
    input  wire logic [9:0]  conv_result,
    output logic      [5:0]  conv_channel,
    output logic             conv_busy
);

    localparam logic [4:0] CONV_LAST = 5'(CONV_QCLKS - 1);

    logic [31:0]   ctrl_r;
    logic [9:0]    ccw_mem [64];
    logic [9:0]    res_mem [64];
    qflags_t       flg_r [2];
    qstate_t       qst_r [2];
    logic [6:0]    ptr_r [2];
    logic [5:0]    last_ptr_r;
    exec_t         ex_r;
    logic          aq_r;
    logic [4:0]    cnt_r;
    logic [5:0]    chan_r;
    logic [1:0]    trig_s1_r;
    logic [1:0]    trig_s2_r;
    logic [1:0]    trig_d_r;
    logic [7:0]    pre_r;
    logic [16:0]   tmr_r;
    logic [1:0]    tmr_use_r;
    logic [31:0]   rdata_r;
    logic          err_r;

    qmode_t        mode [2];
    logic [6:0]    start [2];
    logic [1:0]    trig;
    logic [1:0]    ovr_ev;
    logic [1:0]    cmp_ev;
    logic [1:0]    pause_ev;
    logic          gate_s;
    logic          converter_clock_en;
    logic          tmr_exp;
    logic          tmr_clr;
    logic [3:0]    rate_c;
    logic [17:0]   tmr_span;
    logic [16:0]   tmr_mask;
    ccw_t          conversion_command_word;
    logic [6:0]    cur_ptr;
    logic          end_of_queue_marker;
    logic          conv_done;
    logic          gated_run;
    logic          gate_wrap;
    logic          abort;
    logic          wr_en;
    logic          setup;
    logic          stat_wr;

    // Decode of the operating modes; queue 2 has no gated mode
    always_comb begin
        mode[0] = qmode_t'(ctrl_r[`QC_Q1M_MSB:`QC_Q1M_LSB]);
        mode[1] = qmode_t'(ctrl_r[`QC_Q2M_MSB:`QC_Q2M_LSB]);
        if (mode[1] == MODE_GATED) begin
            mode[1] = MODE_OFF;
        end
        start[0] = 7'h00;
        start[1] = ctrl_r[`QC_BQ2_MSB:`QC_BQ2_LSB];
    end

    // Two-flop synchronisers; edges are taken from the second stage only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_s1_r <= 2'h0;
            trig_s2_r <= 2'h0;
            trig_d_r  <= 2'h0;
        end else begin
            trig_s1_r <= {ext_trig2, ext_trig1};
            trig_s2_r <= trig_s1_r;
            trig_d_r  <= trig_s2_r;
        end
    end

    assign gate_s = trig_s2_r[0];

    // Converter clock enable from the prescaler
    assign converter_clock_en = (pre_r == ctrl_r[`QC_PRE_MSB:`QC_PRE_LSB]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= 8'h00;
        end else if (converter_clock_en) begin
            pre_r <= 8'h00;
        end else begin
            pre_r <= pre_r + 8'h01;
        end
    end

    // Periodic timer: binary divider tapped at the selected power of two
    always_comb begin
        rate_c   = (ctrl_r[`QC_RATE_MSB:`QC_RATE_LSB] > `QC_RATE_MAX) ? `QC_RATE_MAX
                 : ctrl_r[`QC_RATE_MSB:`QC_RATE_LSB];
        tmr_span = 18'h1 << (`QC_TMR_MIN_EXP + {1'b0, rate_c});
        tmr_mask = 17'(tmr_span - 18'h1);
        tmr_exp  = converter_clock_en && ((tmr_r & tmr_mask) == tmr_mask) && (tmr_use_r != 2'h0);
        // Restart on a mode change into the timer, except queue 2 joining queue 1 there, so the first interval is whole
        tmr_clr  = ((mode[0] == MODE_TIMER) && !tmr_use_r[0]) ||
                   ((mode[1] == MODE_TIMER) && !tmr_use_r[1] && (mode[0] != MODE_TIMER));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_r     <= 17'h0;
            tmr_use_r <= 2'h0;
        end else begin
            tmr_use_r <= {mode[1] == MODE_TIMER, mode[0] == MODE_TIMER};
            if (tmr_clr || tmr_use_r == 2'h0) begin
                tmr_r <= 17'h0;
            end else if (tmr_exp) begin
                tmr_r <= 17'h0;
            end else if (converter_clock_en) begin
                tmr_r <= tmr_r + 17'h1;
            end
        end
    end

    // Trigger events per queue and the overruns they cause
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            trig[i] = ((mode[i] == MODE_EXT_RISE) && trig_s2_r[i] && !trig_d_r[i]) ||
                      ((mode[i] == MODE_EXT_FALL) && !trig_s2_r[i] && trig_d_r[i]) ||
                      ((mode[i] == MODE_TIMER) && tmr_exp);
            ovr_ev[i] = trig[i] && (qst_r[i] == Q_ACTIVE);
        end
    end

    // Executor decode
    always_comb begin
        cur_ptr   = aq_r ? ptr_r[1] : ptr_r[0];
        conversion_command_word       = ccw_t'(ccw_mem[cur_ptr[5:0]]);
        end_of_queue_marker       = (cur_ptr >= `QC_TBL_END) || (conversion_command_word.chan == `QC_EOQ_CHAN) ||
                    (!aq_r && (cur_ptr >= start[1]));
        conv_done = (ex_r == EX_CONV) && converter_clock_en && (cnt_r == CONV_LAST);
        gated_run = !aq_r && (mode[0] == MODE_GATED);
        gate_wrap = (ex_r == EX_FETCH) && end_of_queue_marker && gated_run && gate_s;
        abort     = (ex_r == EX_CONV) && aq_r && (qst_r[0] == Q_ACTIVE);
        cmp_ev    = 2'h0;
        pause_ev  = 2'h0;
        if (ex_r == EX_FETCH && end_of_queue_marker) begin
            cmp_ev[aq_r] = 1'b1;
        end
        if (conv_done && gated_run && !gate_s) begin
            pause_ev[0] = 1'b1;
        end else if (conv_done && !abort && conversion_command_word.pause &&
                     (mode[aq_r] != MODE_SW) && (mode[aq_r] != MODE_GATED)) begin
            pause_ev[aq_r] = 1'b1;
        end
    end

    // Queue sequencing and execution
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qst_r[0]   <= Q_IDLE;
            qst_r[1]   <= Q_IDLE;
            ptr_r[0]   <= 7'h00;
            ptr_r[1]   <= 7'h00;
            ex_r       <= EX_IDLE;
            aq_r       <= 1'b0;
            cnt_r      <= 5'h00;
            chan_r     <= 6'h00;
            last_ptr_r <= 6'h00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (mode[i] == MODE_OFF) begin
                    qst_r[i] <= Q_IDLE;
                end else if (qst_r[i] == Q_IDLE &&
                             ((mode[i] == MODE_SW) || trig[i] ||
                              ((mode[i] == MODE_GATED) && gate_s))) begin
                    qst_r[i] <= Q_ACTIVE;
                    ptr_r[i] <= start[i];
                end else if (qst_r[i] == Q_PAUSED && trig[i]) begin
                    qst_r[i] <= Q_ACTIVE;
                end
            end
            case (ex_r)
                EX_IDLE: begin
                    if (qst_r[0] == Q_ACTIVE) begin
                        aq_r <= 1'b0;
                        ex_r <= EX_FETCH;
                    end else if (qst_r[1] == Q_ACTIVE && mode[0] != MODE_SW) begin
                        aq_r <= 1'b1;
                        ex_r <= EX_FETCH;
                    end
                end
                EX_FETCH: begin
                    if (mode[aq_r] == MODE_OFF) begin
                        ex_r <= EX_IDLE;
                    end else if (gate_wrap) begin
                        ptr_r[0] <= start[0];
                    end else if (end_of_queue_marker) begin
                        // Queue shows idle until the next trigger restarts it; in software mode it restarts on the next cycle
                        qst_r[aq_r] <= Q_IDLE;
                        ex_r        <= EX_IDLE;
                    end else begin
                        chan_r <= conversion_command_word.chan;
                        cnt_r  <= 5'h00;
                        ex_r   <= EX_CONV;
                    end
                end
                EX_CONV: begin
                    if (mode[aq_r] == MODE_OFF) begin
                        ex_r <= EX_IDLE;
                    end else if (abort) begin
                        // Queue 2 reruns its whole pass so samples stay coherent
                        ptr_r[1] <= start[1];
                        ex_r     <= EX_IDLE;
                    end else if (converter_clock_en) begin
                        cnt_r <= cnt_r + 5'h01;
                        if (conv_done) begin
                            ptr_r[aq_r] <= cur_ptr + 7'h01;
                            if (!aq_r) begin
                                last_ptr_r <= cur_ptr[5:0];
                            end
                            if (pause_ev != 2'h0) begin
                                // Gate is looked at here between conversions, and at the end-of-queue fetch
                                qst_r[aq_r] <= pause_ev[0] && gated_run ? Q_IDLE
                                             : Q_PAUSED;
                                ex_r        <= EX_IDLE;
                            end else begin
                                ex_r <= EX_FETCH;
                            end
                        end
                    end
                end
                default: begin
                    ex_r <= EX_IDLE;
                end
            endcase
        end
    end

    // Result table write at the end of each conversion, except one that queue 1 aborts in its last cycle
    always_ff @(posedge pclk) begin
        if (conv_done && !abort) begin
            res_mem[cur_ptr[5:0]] <= conv_result;
        end
    end

    // APB slave: data latched in setup, answer in the first access cycle
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite && !err_r;
    assign stat_wr = wr_en && (paddr == `QC_STAT_OFS);
    assign pready  = psel && penable;
    assign pslverr = pready && err_r;
    assign prdata  = rdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h0;
            err_r   <= 1'b0;
        end else if (setup) begin
            rdata_r <= 32'h0;
            err_r   <= 1'b0;
            if (paddr == `QC_CTRL_OFS) begin
                rdata_r <= ctrl_r;
            end else if (paddr == `QC_STAT_OFS) begin
                rdata_r[`QC_ST_Q1F_LSB+:3] <= flg_r[0];
                rdata_r[`QC_ST_Q2F_LSB+:3] <= flg_r[1];
                rdata_r[`QC_ST_Q1S_LSB+:2] <= qst_r[0];
                rdata_r[`QC_ST_Q2S_LSB+:2] <= qst_r[1];
                rdata_r[`QC_ST_PTR_LSB+:6] <= last_ptr_r;
            end else if (paddr[11:8] == `QC_CCW_PAGE && paddr[1:0] == 2'h0) begin
                rdata_r[9:0] <= ccw_mem[paddr[7:2]];
            end else if (paddr[11:8] == `QC_RES_PAGE && paddr[1:0] == 2'h0) begin
                rdata_r[9:0] <= res_mem[paddr[7:2]];
            end else begin
                err_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `QC_CTRL_RST;
        end else if (wr_en && paddr == `QC_CTRL_OFS) begin
            ctrl_r <= pwdata;
        end
    end

    always_ff @(posedge pclk) begin
        if (wr_en && paddr[11:8] == `QC_CCW_PAGE) begin
            ccw_mem[paddr[7:2]] <= pwdata[9:0];
        end
    end

    // Sticky flags: write one to clear, a same-cycle set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flg_r[0] <= '0;
            flg_r[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                flg_r[i].cf  <= cmp_ev[i] ||
                                (flg_r[i].cf && !(stat_wr && pwdata[3*i]));
                flg_r[i].pf  <= pause_ev[i] ||
                                (flg_r[i].pf && !(stat_wr && pwdata[3*i+1]));
                flg_r[i].tor <= ovr_ev[i] ||
                                (i == 0 && gate_wrap && flg_r[0].cf) ||
                                (flg_r[i].tor && !(stat_wr && pwdata[3*i+2]));
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_channel <= 6'h00;
            conv_busy    <= 1'b0;
        end else begin
            conv_channel <= chan_r;
            conv_busy    <= (ex_r == EX_CONV);
        end
    end

    AST_SW_NO_TOR: assert property (@(posedge pclk) disable iff (!presetn)
        (mode[0] == MODE_SW && $past(mode[0]) == MODE_SW) |-> !$rose(flg_r[0].tor))
        else $error("Overrun set in software continuous mode");

    AST_SW_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
        (ex_r == EX_FETCH && end_of_queue_marker && !aq_r && mode[0] == MODE_SW)
        |=> (qst_r[0] == Q_IDLE) ##1 (qst_r[0] == Q_ACTIVE && ptr_r[0] == 7'h00))
        else $error("Software mode did not restart at queue start");

    AST_Q2_LOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        (ex_r == EX_IDLE && mode[0] == MODE_SW) |=> !(ex_r == EX_FETCH && aq_r))
        else $error("Queue 2 ran while queue 1 is in software mode");

    AST_EXT_START: assert property (@(posedge pclk) disable iff (!presetn)
        (trig[1] && qst_r[1] == Q_IDLE && mode[1] == MODE_EXT_RISE && $stable(ctrl_r))
        |=> (qst_r[1] == Q_ACTIVE && ptr_r[1] == $past(start[1])))
        else $error("Edge did not start queue 2");

    AST_PAUSE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        (pause_ev[1] && mode[1] != MODE_OFF)
        |=> (qst_r[1] == Q_PAUSED && flg_r[1].pf && ex_r == EX_IDLE))
        else $error("Pause did not hold queue 2");

    AST_GATE_NO_PAUSE: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_done && gated_run && gate_s && !abort) |=> (ex_r == EX_FETCH && !$rose(flg_r[0].pf)))
        else $error("Gated mode paused");

    AST_GATE_CLOSE: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_done && gated_run && !gate_s)
        |=> (qst_r[0] == Q_IDLE && flg_r[0].pf && last_ptr_r == $past(ptr_r[0][5:0])))
        else $error("Gate closure not recorded");

    AST_GATE_TOR: assert property (@(posedge pclk) disable iff (!presetn)
        (gate_wrap && flg_r[0].cf) |=> (flg_r[0].tor && ptr_r[0] == 7'h00))
        else $error("Gated second completion missed overrun");

    AST_OVERRUN: assert property (@(posedge pclk) disable iff (!presetn)
        (trig[0] && qst_r[0] == Q_ACTIVE) |=> flg_r[0].tor)
        else $error("Trigger during execution not flagged");

    AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
        (abort && mode[1] != MODE_OFF && mode[0] != MODE_OFF)
        |=> (ex_r == EX_IDLE) ##1 (ex_r == EX_FETCH && !aq_r))
        else $error("Queue 1 did not preempt queue 2");

    CVR_SW_WRAP: cover property (@(posedge pclk) disable iff (!presetn)
        cmp_ev[0] && mode[0] == MODE_SW);
    CVR_GATE_WRAP: cover property (@(posedge pclk) disable iff (!presetn) gate_wrap);
    CVR_ABORT: cover property (@(posedge pclk) disable iff (!presetn) abort);
    CVR_TIMER: cover property (@(posedge pclk) disable iff (!presetn)
        tmr_exp && qst_r[1] == Q_PAUSED);

endmodule

// ==== scan_queue_pkg.sv ====
// Types shared by the scan queue controller.
// Assumes scan_queue_regs.svh for the numeric layout.
package scan_queue_pkg;

    typedef enum logic [2:0] {
        MODE_OFF      = 3'b000,
        MODE_SW       = 3'b001,
        MODE_EXT_RISE = 3'b010,
        MODE_EXT_FALL = 3'b011,
        MODE_GATED    = 3'b100,
        MODE_TIMER    = 3'b101
    } qmode_t;

    typedef enum logic [1:0] {
        Q_IDLE   = 2'b00,
        Q_ACTIVE = 2'b01,
        Q_PAUSED = 2'b10
    } qstate_t;

    typedef enum logic [1:0] {
        EX_IDLE  = 2'b00,
        EX_FETCH = 2'b01,
        EX_CONV  = 2'b10
    } exec_t;

    typedef struct packed {
        logic       pause;
        logic       spare;
        logic [1:0] stime;
        logic [5:0] chan;
    } ccw_t;

    typedef struct packed {
        logic tor;
        logic pf;
        logic cf;
    } qflags_t;

endpackage

// ==== scan_queue_regs.svh ====
// Register map, field positions and reset values of the scan queue controller.
// Assumes a 12-bit APB byte address; every register is one aligned 32-bit word.
`ifndef SCAN_QUEUE_REGS_SVH
`define SCAN_QUEUE_REGS_SVH

`define QC_CTRL_OFS      12'h000
`define QC_STAT_OFS      12'h004
`define QC_CCW_PAGE      4'h1
`define QC_RES_PAGE      4'h2
`define QC_CTRL_RST      32'h0004_0000

`define QC_Q1M_MSB       2
`define QC_Q1M_LSB       0
`define QC_Q2M_MSB       6
`define QC_Q2M_LSB       4
`define QC_RATE_MSB      11
`define QC_RATE_LSB      8
`define QC_BQ2_MSB       18
`define QC_BQ2_LSB       12
`define QC_PRE_MSB       31
`define QC_PRE_LSB       24

`define QC_ST_Q1F_LSB    0
`define QC_ST_Q2F_LSB    3
`define QC_ST_Q1S_LSB    8
`define QC_ST_Q2S_LSB    10
`define QC_ST_PTR_LSB    16

`define QC_TBL_END       7'h40
`define QC_EOQ_CHAN      6'h3f
`define QC_TMR_MIN_EXP   5'h07
`define QC_RATE_MAX      4'ha

`endif

// ==== testbench.sv ====
// Self-checking bench for the scan queue controller, APB master and trigger source.
// Assumes zero-wait APB slave and CONV_QCLKS shortened to 8 with prescale 0.
`timescale 1ns/100ps
module testbench;
    import scan_queue_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, ext_trig1, ext_trig2, conv_busy, err, hit;
    logic [9:0]  conv_result;
    logic [5:0]  conv_channel;
    int          n_mismatch, tests_run, cycles;

    scan_queue_ctrl #(.CONV_QCLKS(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_trig1(ext_trig1), .ext_trig2(ext_trig2),
        .conv_result(conv_result), .conv_channel(conv_channel), .conv_busy(conv_busy));
    trig_src i_src (.pclk(pclk), .conv_channel(conv_channel), .ext_trig1(ext_trig1),
        .ext_trig2(ext_trig2), .conv_result(conv_result));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Hang guard: all tests together take under 2000 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_busy(input int n);
        hit = 1'b0;
        repeat (n) begin
            @(posedge pclk);
            if (conv_busy === 1'b1) hit = 1'b1;
        end
    endtask
    task automatic stop_q();
        apb(1'b1, 12'h000, 32'h0004_0000);
        repeat (40) @(posedge pclk);
        apb(1'b1, 12'h004, 32'h0000_003f);
    endtask

    task automatic t_regs();
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl_rst", 32'h0004_0000, rd);
        apb(1'b0, 12'h300, 32'h0);
        chk("unmapped_err", 32'h1, err);
        // Word1 pauses, word2 is the end marker
        apb(1'b1, 12'h100, 32'h0000_0001);
        apb(1'b1, 12'h104, 32'h0000_0202);
        apb(1'b1, 12'h108, 32'h0000_003f);
        apb(1'b0, 12'h104, 32'h0);
        chk("ccw_rb", 32'h0000_0202, rd);
        $display("regs test done");
    endtask
    task automatic t_sw();
        // Queue 2 is also in software mode, so it is ready but must stay locked out
        apb(1'b1, 12'h000, 32'h0004_0011);
        wait_busy(20);
        chk("sw_start", 32'h1, hit);
        repeat (300) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        chk("sw_cf1", 32'h1, rd[0]);
        chk("sw_pf1", 32'h0, rd[1]);
        chk("sw_queue1_trigger_overrun_flag", 32'h0, rd[2]);
        chk("sw_q2_locked", 32'h0, rd[3]);
        apb(1'b0, 12'h200, 32'h0);
        chk("sw_result0", 32'h0000_03d4, rd);
        stop_q();
        $display("software test done");
    endtask
    task automatic t_ext();
        apb(1'b1, 12'h000, 32'h0004_0002);
        wait_busy(30);
        chk("ext_no_start", 32'h0, hit);
        i_src.pulse1(1);
        repeat (80) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        chk("ext_paused", 32'h2, rd[9:8]);
        chk("ext_pf1", 32'h1, rd[1]);
        i_src.pulse1(1);
        repeat (80) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        chk("ext_cf1", 32'h1, rd[0]);
        chk("ext_idle", 32'h0, rd[9:8]);
        chk("ext_tor_none", 32'h0, rd[2]);
        i_src.pulse1(2);
        repeat (80) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        chk("ext_queue1_trigger_overrun_flag", 32'h1, rd[2]);
        stop_q();
        $display("external trigger test done");
    endtask
    task automatic t_gate();
        apb(1'b1, 12'h000, 32'h0004_0004);
        i_src.gate1(1'b1);
        repeat (300) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        chk("gate_cf1", 32'h1, rd[0]);
        chk("gate_queue1_trigger_overrun_flag", 32'h1, rd[2]);
        chk("gate_no_pf1", 32'h0, rd[1]);
        i_src.gate1(1'b0);
        repeat (60) @(posedge pclk);
        wait_busy(40);
        chk("gate_closed", 32'h0, hit);
        apb(1'b0, 12'h004, 32'h0);
        chk("gate_pf1", 32'h1, rd[1]);
        i_src.gate1(1'b1);
        wait_busy(20);
        chk("gate_reopen", 32'h1, hit);
        i_src.gate1(1'b0);
        stop_q();
        $display("gated test done");
    endtask
    task automatic t_timer();
        // Rate 0 gives an interval of 128 converter clocks
        apb(1'b1, 12'h000, 32'h0004_0005);
        wait_busy(100);
        chk("tmr_early", 32'h0, hit);
        wait_busy(100);
        chk("tmr_fire", 32'h1, hit);
        // Second expiry resumes the paused pass, third one restarts it
        repeat (80) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        chk("tmr_resume_cf1", 32'h1, rd[0]);
        chk("tmr_idle", 32'h0, rd[9:8]);
        chk("tmr_no_tor", 32'h0, rd[2]);
        wait_busy(110);
        chk("tmr_restart", 32'h1, hit);
        stop_q();
        $display("timer test done");
    endtask
    task automatic t_q2();
        // Queue 2 owns words 4 and 5; queue 1 keeps words 0 to 2
        apb(1'b1, 12'h110, 32'h0000_0005);
        apb(1'b1, 12'h114, 32'h0000_003f);
        apb(1'b1, 12'h000, 32'h0000_4030);
        i_src.pulse2(1);
        repeat (40) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        chk("q2_fall_cf2", 32'h1, rd[3]);
        chk("q2_idle", 32'h0, rd[11:10]);
        apb(1'b0, 12'h210, 32'h0);
        chk("q2_result", 32'h0000_03d0, rd);
        apb(1'b1, 12'h004, 32'h0000_003f);
        // Queue 1 edge lands inside the first queue 2 conversion
        apb(1'b1, 12'h000, 32'h0000_4022);
        i_src.pulse2(1);
        i_src.pulse1(1);
        repeat (80) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        chk("q1_first_pf1", 32'h1, rd[1]);
        chk("q1_paused", 32'h2, rd[9:8]);
        chk("q2_rerun_cf2", 32'h1, rd[3]);
        stop_q();
        $display("queue 2 test done");
    endtask

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_sw();
        t_ext();
        t_gate();
        t_timer();
        t_q2();
        end_sim();
    end
endmodule

// ==== trig_src.sv ====
// Partner model: external trigger and gate source plus converter result source.
// Assumes the bench calls its tasks from its own thread; pins move after rising pclk.
`timescale 1ns/100ps
module trig_src (
    input  wire logic       pclk,
    input  wire logic [5:0] conv_channel,
    output logic            ext_trig1,
    output logic            ext_trig2,
    output logic      [9:0] conv_result
);
    initial begin
        ext_trig1 = 1'b0;
        ext_trig2 = 1'b0;
    end
    // Result tracks the channel so a stale sample never repeats the last value
    assign conv_result = {4'ha, conv_channel} ^ 10'h155;
    // Rising edges held two cycles, low two cycles, so the synchroniser sees each one
    task automatic pulse1(input int n);
        repeat (n) begin
            @(posedge pclk);
            ext_trig1 <= 1'b1;
            repeat (2) @(posedge pclk);
            ext_trig1 <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic pulse2(input int n);
        repeat (n) begin
            @(posedge pclk);
            ext_trig2 <= 1'b1;
            repeat (2) @(posedge pclk);
            ext_trig2 <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic gate1(input logic v);
        @(posedge pclk);
        ext_trig1 <= v;
    endtask
endmodule
